// >>> hdl/pcs_cfg_pkg.sv
// constants and types for the 100 Mb/s coding sublayer configuration bank
package pcs_cfg_pkg;

  // register addresses on the management port
  localparam logic [4:0] PCS_CONFIG_STATUS_ADDR = 5'h16;
  localparam logic [4:0] PCS_LINK_STATUS_ADDR = 5'h1E;

  // field positions in pcs_100m_config_status
  localparam int PCS_BIT_HOLD = 8;
  localparam int PCS_BIT_TO_SEL = 7;
  localparam int PCS_BIT_FIBER = 6;
  localparam int PCS_BIT_FORCE = 5;
  localparam int PCS_BIT_RSVD = 4;
  localparam int PCS_BIT_FAULT = 3;
  localparam int PCS_BIT_LINE_BYP = 2;
  localparam int PCS_BIT_TX_SKIP = 1;
  localparam int PCS_BIT_RX_SKIP = 0;

  // field positions in the link status register
  localparam int PCS_ST_LINK = 0;
  localparam int PCS_ST_LOCK = 1;
  localparam int PCS_ST_FORCE = 2;
  localparam int PCS_ST_STRAP = 3;

  // reset values of the fields; strapped fields hold PCS_RST_STRAPPED until the strap loads
  localparam logic PCS_RST_HOLD = 1'b1;
  localparam logic PCS_RST_TO_SEL = 1'b0;
  localparam logic PCS_RST_FORCE = 1'b0;
  localparam logic PCS_RST_LINE_BYP = 1'b0;
  localparam logic PCS_RST_STRAPPED = 1'b0;

  // descrambler loss-of-sync timeouts
  localparam int PCS_CLK_PERIOD_NS = 40;
  localparam int PCS_TO_SHORT_NS = 722000;
  localparam int PCS_TO_LONG_NS = 2000000;
  localparam logic [15:0] PCS_TO_SHORT_CYCLES =
    16'((PCS_TO_SHORT_NS + PCS_CLK_PERIOD_NS - 1) / PCS_CLK_PERIOD_NS);
  localparam logic [15:0] PCS_TO_LONG_CYCLES =
    16'((PCS_TO_LONG_NS + PCS_CLK_PERIOD_NS - 1) / PCS_CLK_PERIOD_NS);

  typedef enum logic [0:0] {
    PCS_LINK_DOWN = 1'b0,
    PCS_LINK_UP = 1'b1
  } pcs_link_state_type;

  function automatic logic pcs_addr_hit(input logic [4:0] addr, input logic [4:0] target);
    pcs_addr_hit = (addr == target);
  endfunction : pcs_addr_hit

endpackage : pcs_cfg_pkg

// >>> hdl/pcs_sync_timer.sv
// descrambler lock tracking with selectable loss-of-sync timeout
`timescale 1ns/1ps
module pcs_sync_timer
  import pcs_cfg_pkg::*;
#(
  parameter logic [15:0] P_SHORT_CYCLES = PCS_TO_SHORT_CYCLES,
  parameter logic [15:0] P_LONG_CYCLES = PCS_TO_LONG_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_sync_seen,
  input wire logic i_long,
  output logic o_locked
);

  typedef struct packed {
    logic locked;
    logic [15:0] cnt;
  } pcs_timer_state_type;

  pcs_timer_state_type s_q, s_d;
  logic [15:0] limit;

  assign limit = i_long ? P_LONG_CYCLES : P_SHORT_CYCLES;

  always_comb begin
    s_d = s_q;
    if (i_sync_seen) begin
      s_d.locked = 1'b1;
      s_d.cnt = '0;
    end else if (s_q.locked) begin
      // select may change mid-count; a shrink below cnt drops lock at once
      if (s_q.cnt >= limit - 16'h0001) begin
        s_d.locked = 1'b0;
        s_d.cnt = '0;
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_locked = s_q.locked;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  chk_timeout_length: assert property ( // [RULE3]
    $fell(s_q.locked) |-> $past(s_q.cnt) == $past(limit) - 16'h0001 || $past(s_q.cnt) >= $past(limit))
    else $error("lock dropped at wrong timeout count");

endmodule : pcs_sync_timer

// >>> hdl/pcs_link_fsm.sv
// 100 Mb/s link status decision from signal level and descrambler lock
`timescale 1ns/1ps
module pcs_link_fsm
  import pcs_cfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_signal_valid,
  input wire logic i_locked,
  input wire logic i_hold_policy,
  output logic o_up
);

  typedef struct packed {
    pcs_link_state_type state;
  } pcs_fsm_state_type;

  pcs_fsm_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    unique case (s_q.state)
      PCS_LINK_DOWN: begin
        if (i_signal_valid && i_locked) begin // [RULE1] [RULE2]
          s_d.state = PCS_LINK_UP;
        end
      end
      PCS_LINK_UP: begin
        if (!i_signal_valid) begin // [RULE1] [RULE2]
          s_d.state = PCS_LINK_DOWN;
        end else if (!i_hold_policy && !i_locked) begin // [RULE2]
          s_d.state = PCS_LINK_DOWN;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '{state: PCS_LINK_DOWN};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_up = (s_q.state == PCS_LINK_UP);

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  chk_hold_keeps_link: assert property ( // [RULE1]
    o_up && i_hold_policy && i_signal_valid |=> o_up)
    else $error("link dropped while signal valid under hold policy");

  chk_strict_drop_link: assert property ( // [RULE2]
    o_up && !i_hold_policy && !i_locked |=> !o_up)
    else $error("link kept after lock loss under strict policy");

endmodule : pcs_link_fsm

// >>> hdl/pcs_cfg_bank.sv
// configuration bank and link control for the 100 Mb/s coding sublayer
//
// What this block does
// RULE1 - hold policy set (reset 1): link up on signal plus lock, kept while signal
// RULE2 - hold policy clear: link drops on lost signal or lost descrambler lock
// RULE3 - timeout select: clear gives 722 us loss-of-sync timeout, set gives 2 ms
// RULE4 - fiber mode enable bit turns fiber operation on; loaded set by strap
// RULE5 - software issues a soft reset after changing fiber mode by write
// RULE6 - good 100 Mb/s link forced by register bit OR mac force input
// RULE7 - bit 4 reserved: writes ignored, reads return zero
// RULE8 - far-end fault enable bit turns fault indication on; set by strap
// RULE9 - line-code bypass bit (reset 0) removes inverted line coding when set
// RULE10 - transmit whitener skip bit removes scrambler; set by strap
// RULE11 - receive dewhitener skip bit removes descrambler; set by strap
// RULE12 - strap bits load from the strap sampled on the first clock after reset release, then follow writes
`timescale 1ns/1ps
module pcs_cfg_bank
  import pcs_cfg_pkg::*;
#(
  parameter logic [15:0] P_SHORT_CYCLES = PCS_TO_SHORT_CYCLES,
  parameter logic [15:0] P_LONG_CYCLES = PCS_TO_LONG_CYCLES
) (
  input wire logic I_MCLK,
  input wire logic I_RESET_N,
  input wire logic [4:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_SIGNAL_VALID,
  input wire logic I_SYNC_SEEN,
  input wire logic I_MAC_FORCE_LINK_INPUT,
  input wire logic I_FIBER_STRAP,
  output logic [15:0] O_RDATA,
  output logic O_LINK_UP,
  output logic O_DESC_LOCKED,
  output logic O_FIBER_MODE_ENABLE,
  output logic O_FAR_END_FAULT_ENABLE,
  output logic O_LINE_CODE_BYPASS,
  output logic O_TX_WHITENER_SKIP,
  output logic O_RX_DEWHITENER_SKIP,
  output logic O_DESCRAMBLER_TIMEOUT_SELECT
);

  typedef struct packed {
    logic strap_done;
    logic link_hold_policy;
    logic descrambler_timeout_select;
    logic fiber_mode_enable;
    logic force_good_link;
    logic far_end_fault_enable;
    logic line_code_bypass;
    logic tx_whitener_skip;
    logic rx_dewhitener_skip;
    logic link_up;
    logic desc_locked;
    logic [15:0] rdata;
  } pcs_bank_state_type;

  localparam pcs_bank_state_type PCS_BANK_RESET = '{
    strap_done: 1'b0,
    link_hold_policy: PCS_RST_HOLD,
    descrambler_timeout_select: PCS_RST_TO_SEL,
    fiber_mode_enable: PCS_RST_STRAPPED,
    force_good_link: PCS_RST_FORCE,
    far_end_fault_enable: PCS_RST_STRAPPED,
    line_code_bypass: PCS_RST_LINE_BYP,
    tx_whitener_skip: PCS_RST_STRAPPED,
    rx_dewhitener_skip: PCS_RST_STRAPPED,
    link_up: 1'b0,
    desc_locked: 1'b0,
    rdata: 16'h0000
  };

  pcs_bank_state_type s_q, s_d;

  logic wr_cfg;
  logic rd_cfg;
  logic rd_status;
  logic force_any;
  logic timer_locked;
  logic fsm_up;
  logic [15:0] cfg_image;
  logic [15:0] status_image;

  assign wr_cfg = I_WR && pcs_addr_hit(I_ADDR, PCS_CONFIG_STATUS_ADDR);
  assign rd_cfg = I_RD && pcs_addr_hit(I_ADDR, PCS_CONFIG_STATUS_ADDR);
  assign rd_status = I_RD && pcs_addr_hit(I_ADDR, PCS_LINK_STATUS_ADDR);

  // the mac pin is taken as is, no filtering
  assign force_any = s_q.force_good_link || I_MAC_FORCE_LINK_INPUT; // [RULE6]

  // loss-of-sync timer; lock comes from sync events, not from software
  pcs_sync_timer #(
    .P_SHORT_CYCLES(P_SHORT_CYCLES),
    .P_LONG_CYCLES(P_LONG_CYCLES)
  ) u_timer (
    .i_clk(I_MCLK),
    .i_reset_n(I_RESET_N),
    .i_sync_seen(I_SYNC_SEEN),
    .i_long(s_q.descrambler_timeout_select), // [RULE3]
    .o_locked(timer_locked)
  );

  pcs_link_fsm u_fsm (
    .i_clk(I_MCLK),
    .i_reset_n(I_RESET_N),
    .i_signal_valid(I_SIGNAL_VALID),
    .i_locked(timer_locked),
    .i_hold_policy(s_q.link_hold_policy), // [RULE1] [RULE2]
    .o_up(fsm_up)
  );

  // upper bits belong to other logic and read as zero here
  always_comb begin
    cfg_image = 16'h0000;
    cfg_image[PCS_BIT_HOLD] = s_q.link_hold_policy;
    cfg_image[PCS_BIT_TO_SEL] = s_q.descrambler_timeout_select;
    cfg_image[PCS_BIT_FIBER] = s_q.fiber_mode_enable;
    cfg_image[PCS_BIT_FORCE] = s_q.force_good_link;
    cfg_image[PCS_BIT_RSVD] = 1'b0; // [RULE7]
    cfg_image[PCS_BIT_FAULT] = s_q.far_end_fault_enable;
    cfg_image[PCS_BIT_LINE_BYP] = s_q.line_code_bypass;
    cfg_image[PCS_BIT_TX_SKIP] = s_q.tx_whitener_skip;
    cfg_image[PCS_BIT_RX_SKIP] = s_q.rx_dewhitener_skip;
  end

  always_comb begin
    status_image = 16'h0000;
    status_image[PCS_ST_LINK] = s_q.link_up;
    status_image[PCS_ST_LOCK] = s_q.desc_locked;
    status_image[PCS_ST_FORCE] = force_any;
    status_image[PCS_ST_STRAP] = s_q.strap_done;
  end

  always_comb begin
    s_d = s_q;
    s_d.strap_done = 1'b1;
    if (!s_q.strap_done) begin
      // strap is sampled on the first edge after release, never by the reset
      s_d.fiber_mode_enable = I_FIBER_STRAP; // [RULE4] [RULE12]
      s_d.far_end_fault_enable = I_FIBER_STRAP; // [RULE8] [RULE12]
      s_d.tx_whitener_skip = I_FIBER_STRAP; // [RULE10] [RULE12]
      s_d.rx_dewhitener_skip = I_FIBER_STRAP; // [RULE11] [RULE12]
    end else if (wr_cfg) begin
      // fiber change needs a soft reset elsewhere; nothing is sequenced here
      s_d.fiber_mode_enable = I_WDATA[PCS_BIT_FIBER]; // [RULE4] [RULE5]
      s_d.far_end_fault_enable = I_WDATA[PCS_BIT_FAULT]; // [RULE8]
      s_d.tx_whitener_skip = I_WDATA[PCS_BIT_TX_SKIP]; // [RULE10]
      s_d.rx_dewhitener_skip = I_WDATA[PCS_BIT_RX_SKIP]; // [RULE11]
    end
    // non-strap fields accept a write even in the strap cycle
    if (wr_cfg) begin
      s_d.link_hold_policy = I_WDATA[PCS_BIT_HOLD]; // [RULE1] [RULE2]
      s_d.descrambler_timeout_select = I_WDATA[PCS_BIT_TO_SEL]; // [RULE3]
      s_d.force_good_link = I_WDATA[PCS_BIT_FORCE]; // [RULE6]
      s_d.line_code_bypass = I_WDATA[PCS_BIT_LINE_BYP]; // [RULE9]
    end
    s_d.link_up = fsm_up || force_any; // [RULE6]
    s_d.desc_locked = timer_locked;
    // read data stand for exactly one cycle, zero otherwise
    if (rd_cfg) begin
      s_d.rdata = cfg_image;
    end else if (rd_status) begin
      s_d.rdata = status_image;
    end else begin
      s_d.rdata = 16'h0000;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      s_q <= PCS_BANK_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign O_RDATA = s_q.rdata;
  assign O_LINK_UP = s_q.link_up;
  assign O_DESC_LOCKED = s_q.desc_locked;
  assign O_FIBER_MODE_ENABLE = s_q.fiber_mode_enable;
  assign O_FAR_END_FAULT_ENABLE = s_q.far_end_fault_enable;
  assign O_LINE_CODE_BYPASS = s_q.line_code_bypass;
  assign O_TX_WHITENER_SKIP = s_q.tx_whitener_skip;
  assign O_RX_DEWHITENER_SKIP = s_q.rx_dewhitener_skip;
  assign O_DESCRAMBLER_TIMEOUT_SELECT = s_q.descrambler_timeout_select;

  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);

  sequence cfg_write_s;
    s_q.strap_done && wr_cfg;
  endsequence

  sequence cfg_read_s;
    rd_cfg;
  endsequence

  sequence strap_cycle_s;
    !s_q.strap_done;
  endsequence

  chk_force_link_or: assert property ( // [RULE6]
    force_any |=> O_LINK_UP)
    else $error("forced link not shown one cycle later");

  chk_link_no_cause: assert property ( // [RULE6]
    !fsm_up && !force_any |=> !O_LINK_UP)
    else $error("link up with neither fsm nor force");

  chk_reserved_reads_zero: assert property ( // [RULE7]
    cfg_read_s |=> O_RDATA[PCS_BIT_RSVD] == 1'b0)
    else $error("reserved bit read as one");

  chk_read_config_image: assert property ( // [RULE9]
    cfg_read_s ##1 !$past(wr_cfg) |-> O_RDATA[8:0] == cfg_image[8:0])
    else $error("config read data differ from stored fields");

  chk_strap_load_fields: assert property ( // [RULE12]
    strap_cycle_s |=> O_FIBER_MODE_ENABLE == $past(I_FIBER_STRAP)
      && O_FAR_END_FAULT_ENABLE == $past(I_FIBER_STRAP)
      && O_TX_WHITENER_SKIP == $past(I_FIBER_STRAP)
      && O_RX_DEWHITENER_SKIP == $past(I_FIBER_STRAP))
    else $error("strap bits not loaded from strap");

  chk_fiber_write_takes: assert property ( // [RULE4]
    cfg_write_s |=> O_FIBER_MODE_ENABLE == $past(I_WDATA[PCS_BIT_FIBER]))
    else $error("fiber mode write not stored");

  chk_skip_write_takes: assert property ( // [RULE10]
    cfg_write_s |=> O_TX_WHITENER_SKIP == $past(I_WDATA[PCS_BIT_TX_SKIP])
      && O_RX_DEWHITENER_SKIP == $past(I_WDATA[PCS_BIT_RX_SKIP]))
    else $error("whitener skip write not stored");

  chk_fault_write_takes: assert property ( // [RULE8]
    cfg_write_s |=> O_FAR_END_FAULT_ENABLE == $past(I_WDATA[PCS_BIT_FAULT]))
    else $error("far-end fault write not stored");

  chk_strap_bits_hold: assert property ( // [RULE11]
    s_q.strap_done && !wr_cfg |=> $stable(O_RX_DEWHITENER_SKIP))
    else $error("strap bit changed without a write");

  chk_bypass_write_takes: assert property ( // [RULE9]
    wr_cfg |=> O_LINE_CODE_BYPASS == $past(I_WDATA[PCS_BIT_LINE_BYP]))
    else $error("line-code bypass write not stored");

  chk_timeout_select_path: assert property ( // [RULE3]
    wr_cfg |=> O_DESCRAMBLER_TIMEOUT_SELECT == $past(I_WDATA[PCS_BIT_TO_SEL]))
    else $error("timeout select write not stored");

  chk_policy_reset_value: assert property ( // [RULE1]
    strap_cycle_s and !wr_cfg |-> s_q.link_hold_policy == PCS_RST_HOLD)
    else $error("hold policy not at reset value");

  chk_rdata_one_cycle: assert property (
    !I_RD |=> O_RDATA == 16'h0000)
    else $error("read data present without a read");

endmodule : pcs_cfg_bank

// >>> tb/test_pcs_cfg_bank.sv
// self-checking bench for the coding sublayer configuration bank
`timescale 1ns/1ps
module test_pcs_cfg_bank;
  import pcs_cfg_pkg::*;

  localparam logic [15:0] SHORT_C = 16'h0014;
  localparam logic [15:0] LONG_C = 16'h0032;

  typedef struct packed {
    logic [15:0] wdata;
    logic [15:0] rexp;
  } pcs_row_type;

  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sig_valid = 1'b0;
  logic sync_seen = 1'b0;
  logic mac_force = 1'b0;
  logic strap = 1'b0;
  logic [15:0] rdata;
  logic link_up;
  logic locked;
  logic fiber;
  logic fault;
  logic line_byp;
  logic tx_skip;
  logic rx_skip;
  logic to_sel;
  logic [15:0] rd_val;
  int num_errors = 0;
  int comparisons = 0;

  // bit 4 and the unimplemented top bits always drop out of the image
  pcs_row_type rows [7] = '{
    '{16'hFFFF, 16'h01EF}, '{16'h0010, 16'h0000}, '{16'h0104, 16'h0104},
    '{16'h0180, 16'h0180}, '{16'h0148, 16'h0148}, '{16'h0103, 16'h0103},
    '{16'hFE00, 16'h0000}};

  always #20 mclk = ~mclk;

  pcs_cfg_bank #(.P_SHORT_CYCLES(SHORT_C), .P_LONG_CYCLES(LONG_C)) dut (
    .I_MCLK(mclk),
    .I_RESET_N(reset_n),
    .I_ADDR(addr),
    .I_WDATA(wdata),
    .I_WR(wr),
    .I_RD(rd),
    .I_SIGNAL_VALID(sig_valid),
    .I_SYNC_SEEN(sync_seen),
    .I_MAC_FORCE_LINK_INPUT(mac_force),
    .I_FIBER_STRAP(strap),
    .O_RDATA(rdata),
    .O_LINK_UP(link_up),
    .O_DESC_LOCKED(locked),
    .O_FIBER_MODE_ENABLE(fiber),
    .O_FAR_END_FAULT_ENABLE(fault),
    .O_LINE_CODE_BYPASS(line_byp),
    .O_TX_WHITENER_SKIP(tx_skip),
    .O_RX_DEWHITENER_SKIP(rx_skip),
    .O_DESCRAMBLER_TIMEOUT_SELECT(to_sel)
  );

  task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cycles

  // fields are sampled one time unit after the edge that takes the write
  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask : reg_write

  task automatic reg_read(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_read

  task automatic sync_pulse();
    @(posedge mclk);
    sync_seen <= 1'b1;
    @(posedge mclk);
    sync_seen <= 1'b0;
    #1;
  endtask : sync_pulse

  task automatic do_reset(input logic s);
    @(posedge mclk);
    reset_n <= 1'b0;
    strap <= s;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    cycles(3);
  endtask : do_reset

  task automatic finish_test();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    #(40 * 5000);
    num_errors++;
    finish_test();
  end

  initial begin
    do_reset(1'b0);
    reg_read(PCS_CONFIG_STATUS_ADDR, rd_val);
    check_word("reset image", 16'h0100, rd_val);
    // read data stand for one cycle only, so look one edge later
    cycles(1);
    check_word("idle rdata", 16'h0000, rdata);
    foreach (rows[i]) begin
      reg_write(PCS_CONFIG_STATUS_ADDR, rows[i].wdata);
      check_bit("timeout select", rows[i].rexp[PCS_BIT_TO_SEL], to_sel);
      check_bit("fiber mode", rows[i].rexp[PCS_BIT_FIBER], fiber);
      check_bit("far end fault", rows[i].rexp[PCS_BIT_FAULT], fault);
      check_bit("line bypass", rows[i].rexp[PCS_BIT_LINE_BYP], line_byp);
      check_bit("tx skip", rows[i].rexp[PCS_BIT_TX_SKIP], tx_skip);
      check_bit("rx skip", rows[i].rexp[PCS_BIT_RX_SKIP], rx_skip);
      reg_read(PCS_CONFIG_STATUS_ADDR, rd_val);
      check_word("readback", rows[i].rexp, rd_val);
    end
    // unmapped address neither stores nor answers
    reg_write(5'h05, 16'hFFFF);
    reg_read(5'h05, rd_val);
    check_word("unmapped read", 16'h0000, rd_val);
    reg_read(PCS_CONFIG_STATUS_ADDR, rd_val);
    check_word("image after unmapped", 16'h0000, rd_val);
    // forced link from the register bit, then from the mac input
    reg_write(PCS_CONFIG_STATUS_ADDR, 16'h0020);
    cycles(3);
    check_bit("link forced by bit", 1'b1, link_up);
    reg_read(PCS_LINK_STATUS_ADDR, rd_val);
    check_bit("force status", 1'b1, rd_val[PCS_ST_FORCE]);
    reg_write(PCS_CONFIG_STATUS_ADDR, 16'h0000);
    cycles(3);
    check_bit("link unforced", 1'b0, link_up);
    @(posedge mclk);
    mac_force <= 1'b1;
    cycles(3);
    check_bit("link forced by mac", 1'b1, link_up);
    @(posedge mclk);
    mac_force <= 1'b0;
    cycles(3);
    check_bit("link released", 1'b0, link_up);
    // policy clear: lost lock drops link after the short timeout
    @(posedge mclk);
    sig_valid <= 1'b1;
    sync_pulse();
    cycles(5);
    check_bit("link up strict", 1'b1, link_up);
    cycles(9);
    check_bit("lock held short", 1'b1, locked);
    cycles(10);
    check_bit("lock lost short", 1'b0, locked);
    cycles(3);
    check_bit("link lost on lock", 1'b0, link_up);
    // long timeout keeps lock past the short limit
    reg_write(PCS_CONFIG_STATUS_ADDR, 16'h0080);
    sync_pulse();
    cycles(39);
    check_bit("lock held long", 1'b1, locked);
    cycles(20);
    check_bit("lock lost long", 1'b0, locked);
    // policy set: link survives lost lock, falls with the signal
    reg_write(PCS_CONFIG_STATUS_ADDR, 16'h0100);
    sync_pulse();
    cycles(5);
    check_bit("link up hold", 1'b1, link_up);
    cycles(30);
    check_bit("lock gone", 1'b0, locked);
    check_bit("link kept", 1'b1, link_up);
    @(posedge mclk);
    sig_valid <= 1'b0;
    cycles(4);
    check_bit("link down no signal", 1'b0, link_up);
    sync_pulse();
    cycles(4);
    check_bit("no link without signal", 1'b0, link_up);
    // strap high reloads the strap fields, writes then override them
    do_reset(1'b1);
    reg_read(PCS_CONFIG_STATUS_ADDR, rd_val);
    check_word("strap image", 16'h014B, rd_val);
    check_bit("strap fiber", 1'b1, fiber);
    reg_write(PCS_CONFIG_STATUS_ADDR, 16'h0100);
    cycles(4);
    reg_read(PCS_CONFIG_STATUS_ADDR, rd_val);
    check_word("strap overwritten", 16'h0100, rd_val);
    check_bit("tx skip cleared", 1'b0, tx_skip);
    check_bit("rx skip cleared", 1'b0, rx_skip);
    // fiber mode was changed by a write, so software resets before relying on it
    do_reset(1'b0);
    reg_read(PCS_CONFIG_STATUS_ADDR, rd_val);
    check_word("image after soft reset", 16'h0100, rd_val);
    check_bit("fiber after soft reset", 1'b0, fiber);
    finish_test();
  end

endmodule : test_pcs_cfg_bank
